//--- design/synth_vco_cal_override_regs.sv
// oscillator calibration override and charge pump configuration bank on avalon-mm
// register map, byte address = 4 x index, data in bits 15:0
//   00h main control, bit 1 soft reset
//   08h force control, bits 14 and 11
//   0Dh fixed word a
//   0Eh pump gain, code in bits 6:3
//   0Fh fixed word b
//   10h bias override, bits 8:0
//   11h bias start, bits 8:0
//   12h fixed word c
//   13h band override, bits 7:0
//   14h core select, bits 13:11, force bit 10
//   15h fixed word d
//   16h fixed word e
//   30h calibration control, bit 0
//   31h status, read only
//   others ignore writes, read zero
//
// status word
//   bit 0 pump tri-stated
//   bit 1 band code in range
//   bit 2 core code in range
//   bit 3 start enable
//
// bus timing
//   requests are taken only while idle
//   writes land at the taking edge
//   waitrequest is low one cycle later
//   read data stand in that cycle
//   each access takes two cycles
//
// output timing
//   outputs come from flip-flops
//   fields follow a write one edge after the taking edge
//   fields hold until rewritten
//   applied settings lag the calibration inputs one edge
//   soft reset reloads one edge later
//
// limitations
//   fill patterns are not enforced
//   odd band and core codes still apply
//   pump current saturates above code ten
//   byte lanes 2 and 3 are ignored
//   soft reset keeps user fields
//
// The Avalon-MM register port was left to the implementer.
module synth_vco_cal_override_regs
	import synth_cfg_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// avalon-mm slave
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic [31:0]      readdata,
	output logic             waitrequest,
	// calibration engine results
	input  wire logic [8:0]  cal_bias_current,
	input  wire logic [7:0]  cal_band_code,
	input  wire logic [2:0]  cal_core_select,
	// calibration start settings
	output logic [8:0]       osc_bias_cal_start_value,
	output logic [2:0]       cal_start_core,
	output logic             osc_core_start_enable,
	// settings applied to the oscillator
	output logic [8:0]       osc_bias_applied,
	output logic [7:0]       osc_band_applied,
	output logic [2:0]       osc_core_applied,
	// charge pump
	output logic [3:0]       charge_pump_gain,
	output logic             pump_tristate,
	output logic [12:0]      pump_current_ua
);

	////////////////////////////////////////////////////////////////////////////////
	// state of the bank

	// every stored word of the bank plus the output flops, except waitrequest and the applied settings
	typedef struct packed {
		logic [15:0] force_ctrl;
		logic [15:0] fixed_a;
		logic [15:0] pump;
		logic [15:0] fixed_b;
		logic [15:0] bias_ovr;
		logic [15:0] bias_start;
		logic [15:0] fixed_c;
		logic [15:0] band_ovr;
		logic [15:0] core_sel;
		logic [15:0] fixed_d;
		logic [15:0] fixed_e;
		logic [15:0] cal_ctrl;
		logic        soft_reset;
		logic [31:0] rdata;
		logic [8:0]  start_bias;
		logic [2:0]  start_core;
		logic        start_en;
		logic [3:0]  gain;
		logic        tristate;
		logic [12:0] current;
	} bank_state_t;

	// current and next state
	bank_state_t state_reg;
	bank_state_t state_next;

	// reset image: power-on words, outputs to match except pump current, which starts at zero
	localparam bank_state_t BANK_RESET = '{
		force_ctrl: RST_FORCE_CTRL,
		fixed_a:    RST_FIXED_A,
		pump:       RST_PUMP,
		fixed_b:    RST_FIXED_B,
		bias_ovr:   RST_BIAS_OVR,
		bias_start: RST_BIAS_START,
		fixed_c:    RST_FIXED_C,
		band_ovr:   RST_BAND_OVR,
		core_sel:   RST_CORE_SEL,
		fixed_d:    RST_FIXED_D,
		fixed_e:    RST_FIXED_E,
		cal_ctrl:   RST_CAL_CTRL,
		soft_reset: 1'b0,
		rdata:      '0,
		start_bias: RST_BIAS_START[BIAS_MSB:0],
		start_core: RST_CORE_SEL[CORE_SEL_MSB:CORE_SEL_LSB],
		start_en:   1'b0,
		gain:       RST_PUMP[PUMP_GAIN_MSB:PUMP_GAIN_LSB],
		tristate:   1'b0,
		current:    13'h0000
	};

	////////////////////////////////////////////////////////////////////////////////
	// submodules

	// one carrier for strobes and selector
	cfg_link_if link ();

	// word index, read word, pump scaling, status
	logic [5:0]  acc_index;
	logic [15:0] reg_wdata;
	logic [13:0] pump_product;
	logic [3:0]  status_bits;

	// byte offset within a word is ignored
	assign acc_index = address[7:IDX_LSB];

	// bus handshake: strobes and waitrequest
	avalon_wait_ctrl u_wait (
		.clk_sys     (clk_sys),
		.rst_n       (rst_n),
		.read        (read),
		.write       (write),
		.waitrequest (waitrequest),
		.link        (link.bus_mp)
	);

	// registered choice of programmed or calibrated settings
	osc_override_sel u_sel (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.link    (link.sel_mp)
	);

	// settings handed to the override selector
	assign link.bias_force = state_reg.force_ctrl[FORCE_BIAS_BIT];
	assign link.band_force = state_reg.force_ctrl[FORCE_BAND_BIT];
	assign link.core_force = state_reg.core_sel[CORE_FORCE_BIT];
	assign link.bias_val   = state_reg.bias_ovr[BIAS_MSB:0];
	assign link.band_val   = state_reg.band_ovr[BAND_MSB:0];
	assign link.core_val   = state_reg.core_sel[CORE_SEL_MSB:CORE_SEL_LSB];
	assign link.cal_bias   = cal_bias_current;
	assign link.cal_band   = cal_band_code;
	assign link.cal_core   = cal_core_select;

	// top outputs, each from a flip-flop
	assign readdata                 = state_reg.rdata;
	assign osc_bias_cal_start_value = state_reg.start_bias;
	assign cal_start_core           = state_reg.start_core;
	assign osc_core_start_enable    = state_reg.start_en;
	assign osc_bias_applied         = link.bias_out;
	assign osc_band_applied         = link.band_out;
	assign osc_core_applied         = link.core_out;
	assign charge_pump_gain         = state_reg.gain;
	assign pump_tristate            = state_reg.tristate;
	assign pump_current_ua          = state_reg.current;

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	// merge the two low byte lanes of a write into a stored word
	function automatic logic [15:0] lane_merge(input logic [15:0] old_val, input logic [31:0] wdata,
		input logic [3:0] be);
		logic [15:0] merged;
		merged = old_val;
		for (int lane = 0; lane < 2; lane++) begin
			if (be[lane]) begin
				merged[lane*8 +: 8] = wdata[lane*8 +: 8];
			end
		end
		return merged;
	endfunction : lane_merge

	// pump current is gain times step, capped at the top figure
	assign pump_product = 14'({10'h000, state_reg.pump[PUMP_GAIN_MSB:PUMP_GAIN_LSB]} * PUMP_STEP_UA);

	// status: pump off, band in range, core code valid, calibration start enabled
	assign status_bits = {
		state_reg.cal_ctrl[CAL_START_EN_BIT],
		(state_reg.core_sel[CORE_SEL_MSB:CORE_SEL_LSB] >= CORE_MIN) &&
			(state_reg.core_sel[CORE_SEL_MSB:CORE_SEL_LSB] <= CORE_MAX),
		state_reg.band_ovr[BAND_MSB:0] <= BAND_CODE_MAX,
		state_reg.pump[PUMP_GAIN_MSB:PUMP_GAIN_LSB] == PUMP_OFF
	};

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		// defaults: hold every word, no reset pulse, no read word
		reg_wdata  = '0;
		state_next = state_reg;
		state_next.soft_reset = 1'b0;

		// register writes, held exactly as written
		if (link.acc_wr) begin
			if (acc_index == IDX_MAIN_CTRL) begin
				state_next.soft_reset = writedata[MAIN_RESET_BIT] && byteenable[0];
			end else if (acc_index == IDX_FORCE_CTRL) begin
				state_next.force_ctrl = lane_merge(state_reg.force_ctrl, writedata, byteenable);
			end else if (acc_index == IDX_FIXED_A) begin
				state_next.fixed_a = lane_merge(state_reg.fixed_a, writedata, byteenable);
			end else if (acc_index == IDX_PUMP) begin
				state_next.pump = lane_merge(state_reg.pump, writedata, byteenable);
			end else if (acc_index == IDX_FIXED_B) begin
				state_next.fixed_b = lane_merge(state_reg.fixed_b, writedata, byteenable);
			end else if (acc_index == IDX_BIAS_OVR) begin
				state_next.bias_ovr = lane_merge(state_reg.bias_ovr, writedata, byteenable);
			end else if (acc_index == IDX_BIAS_START) begin
				state_next.bias_start = lane_merge(state_reg.bias_start, writedata, byteenable);
			end else if (acc_index == IDX_FIXED_C) begin
				state_next.fixed_c = lane_merge(state_reg.fixed_c, writedata, byteenable);
			end else if (acc_index == IDX_BAND_OVR) begin
				state_next.band_ovr = lane_merge(state_reg.band_ovr, writedata, byteenable);
			end else if (acc_index == IDX_CORE_SEL) begin
				state_next.core_sel = lane_merge(state_reg.core_sel, writedata, byteenable);
			end else if (acc_index == IDX_FIXED_D) begin
				state_next.fixed_d = lane_merge(state_reg.fixed_d, writedata, byteenable);
			end else if (acc_index == IDX_FIXED_E) begin
				state_next.fixed_e = lane_merge(state_reg.fixed_e, writedata, byteenable);
			end else if (acc_index == IDX_CAL_CTRL) begin
				state_next.cal_ctrl = lane_merge(state_reg.cal_ctrl, writedata, byteenable);
			end
		end

		// software reset reloads the fixed-pattern words, the cycle after it is written
		if (state_reg.soft_reset) begin
			state_next.fixed_a = RST_FIXED_A;
			state_next.fixed_b = RST_FIXED_B;
			state_next.fixed_c = RST_FIXED_C;
			state_next.fixed_d = RST_FIXED_D;
			state_next.fixed_e = RST_FIXED_E;
		end

		// register reads, no side effects; unmapped words and the main control word read zero
		if (link.acc_rd) begin
			if (acc_index == IDX_FORCE_CTRL) begin
				reg_wdata = state_reg.force_ctrl;
			end else if (acc_index == IDX_FIXED_A) begin
				reg_wdata = state_reg.fixed_a;
			end else if (acc_index == IDX_PUMP) begin
				reg_wdata = state_reg.pump;
			end else if (acc_index == IDX_FIXED_B) begin
				reg_wdata = state_reg.fixed_b;
			end else if (acc_index == IDX_BIAS_OVR) begin
				reg_wdata = state_reg.bias_ovr;
			end else if (acc_index == IDX_BIAS_START) begin
				reg_wdata = state_reg.bias_start;
			end else if (acc_index == IDX_FIXED_C) begin
				reg_wdata = state_reg.fixed_c;
			end else if (acc_index == IDX_BAND_OVR) begin
				reg_wdata = state_reg.band_ovr;
			end else if (acc_index == IDX_CORE_SEL) begin
				reg_wdata = state_reg.core_sel;
			end else if (acc_index == IDX_FIXED_D) begin
				reg_wdata = state_reg.fixed_d;
			end else if (acc_index == IDX_FIXED_E) begin
				reg_wdata = state_reg.fixed_e;
			end else if (acc_index == IDX_CAL_CTRL) begin
				reg_wdata = state_reg.cal_ctrl;
			end else if (acc_index == IDX_STATUS) begin
				reg_wdata = {12'h000, status_bits};
			end
			// upper half of the bus word reads zero
			state_next.rdata = {16'h0000, reg_wdata};
		end

		// calibration start settings
		state_next.start_bias = state_reg.bias_start[BIAS_MSB:0];
		state_next.start_core = state_reg.core_sel[CORE_SEL_MSB:CORE_SEL_LSB];
		state_next.start_en   = state_reg.cal_ctrl[CAL_START_EN_BIT];

		// charge pump drive
		state_next.gain     = state_reg.pump[PUMP_GAIN_MSB:PUMP_GAIN_LSB];
		state_next.tristate = state_reg.pump[PUMP_GAIN_MSB:PUMP_GAIN_LSB] == PUMP_OFF;
		if (pump_product > PUMP_MAX_UA) begin
			state_next.current = PUMP_MAX_UA[12:0];
		end else begin
			state_next.current = pump_product[12:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	// asynchronous reset loads the reset image
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= BANK_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

endmodule : synth_vco_cal_override_regs

//--- design/synth_cfg_pkg.sv
// constants, field layouts and state types shared by the oscillator configuration bank
package synth_cfg_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register indices (byte address is four times the index)
	localparam int          IDX_LSB        = 2;
	localparam logic [5:0]  IDX_MAIN_CTRL  = 6'h00;
	localparam logic [5:0]  IDX_FORCE_CTRL = 6'h08;
	localparam logic [5:0]  IDX_FIXED_A    = 6'h0D;
	localparam logic [5:0]  IDX_PUMP       = 6'h0E;
	localparam logic [5:0]  IDX_FIXED_B    = 6'h0F;
	localparam logic [5:0]  IDX_BIAS_OVR   = 6'h10;
	localparam logic [5:0]  IDX_BIAS_START = 6'h11;
	localparam logic [5:0]  IDX_FIXED_C    = 6'h12;
	localparam logic [5:0]  IDX_BAND_OVR   = 6'h13;
	localparam logic [5:0]  IDX_CORE_SEL   = 6'h14;
	localparam logic [5:0]  IDX_FIXED_D    = 6'h15;
	localparam logic [5:0]  IDX_FIXED_E    = 6'h16;
	localparam logic [5:0]  IDX_CAL_CTRL   = 6'h30;
	localparam logic [5:0]  IDX_STATUS     = 6'h31;

	////////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [15:0] RST_FORCE_CTRL = 16'h2000;
	localparam logic [15:0] RST_FIXED_A    = 16'h4000;
	localparam logic [15:0] RST_PUMP       = 16'h1840;
	localparam logic [15:0] RST_FIXED_B    = 16'h060E;
	localparam logic [15:0] RST_BIAS_OVR   = 16'h0080;
	localparam logic [15:0] RST_BIAS_START = 16'h0096;
	localparam logic [15:0] RST_FIXED_C    = 16'h0064;
	localparam logic [15:0] RST_BAND_OVR   = 16'h27B7;
	localparam logic [15:0] RST_CORE_SEL   = 16'h3048;
	localparam logic [15:0] RST_FIXED_D    = 16'h0409;
	localparam logic [15:0] RST_FIXED_E    = 16'h0001;
	localparam logic [15:0] RST_CAL_CTRL   = 16'h0000;

	////////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int          MAIN_RESET_BIT   = 1;
	localparam int          FORCE_BIAS_BIT   = 14;
	localparam int          FORCE_BAND_BIT   = 11;
	localparam int          PUMP_GAIN_LSB    = 3;
	localparam int          PUMP_GAIN_MSB    = 6;
	localparam int          BIAS_MSB         = 8;
	localparam int          BAND_MSB         = 7;
	localparam int          CORE_SEL_LSB     = 11;
	localparam int          CORE_SEL_MSB     = 13;
	localparam int          CORE_FORCE_BIT   = 10;
	localparam int          CAL_START_EN_BIT = 0;

	////////////////////////////////////////////////////////////////////////////////
	// value limits and pump scaling
	localparam logic [7:0]  BAND_CODE_MAX = 8'hB7;
	localparam logic [2:0]  CORE_MIN      = 3'h1;
	localparam logic [2:0]  CORE_MAX      = 3'h6;
	localparam logic [3:0]  PUMP_OFF      = 4'h0;
	localparam logic [13:0] PUMP_STEP_UA  = 14'h0271;
	localparam logic [13:0] PUMP_MAX_UA   = 14'h1ADB;

	////////////////////////////////////////////////////////////////////////////////
	// state types
	typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_t;

	typedef struct packed {
		bus_state_t state;
		logic       waitrequest;
	} bus_ctrl_state_t;

	typedef struct packed {
		logic [8:0] bias;
		logic [7:0] band;
		logic [2:0] core;
	} osc_apply_state_t;

endpackage : synth_cfg_pkg

//--- design/cfg_link_if.sv
// carrier between the bank, its bus handshake and the oscillator override selector
interface cfg_link_if;
	import synth_cfg_pkg::*;
	logic       acc_wr;
	logic       acc_rd;
	logic       bias_force;
	logic       band_force;
	logic       core_force;
	logic [8:0] bias_val;
	logic [7:0] band_val;
	logic [2:0] core_val;
	logic [8:0] cal_bias;
	logic [7:0] cal_band;
	logic [2:0] cal_core;
	logic [8:0] bias_out;
	logic [7:0] band_out;
	logic [2:0] core_out;

	modport bus_mp (output acc_wr, acc_rd);
	modport bank_bus_mp (input acc_wr, acc_rd);
	modport sel_mp (input bias_force, band_force, core_force, bias_val, band_val, core_val,
		cal_bias, cal_band, cal_core, output bias_out, band_out, core_out);
	modport bank_sel_mp (output bias_force, band_force, core_force, bias_val, band_val, core_val,
		cal_bias, cal_band, cal_core, input bias_out, band_out, core_out);
endinterface : cfg_link_if

//--- design/avalon_wait_ctrl.sv
// avalon handshake: one access strobe per request and a registered waitrequest
module avalon_wait_ctrl
	import synth_cfg_pkg::*;
(
	// clock and reset
	input  wire logic   clk_sys,
	input  wire logic   rst_n,
	// bus request
	input  wire logic   read,
	input  wire logic   write,
	output logic        waitrequest,
	// access strobes to the bank
	cfg_link_if.bus_mp  link
);

	bus_ctrl_state_t state_reg;
	bus_ctrl_state_t state_next;

	// strobe only in idle so a held request is taken once
	assign link.acc_wr = write && (state_reg.state == BUS_IDLE);
	assign link.acc_rd = read && !write && (state_reg.state == BUS_IDLE);
	assign waitrequest = state_reg.waitrequest;

	// idle takes the request, ack drops waitrequest for one cycle
	always_comb begin
		state_next = state_reg;
		case (state_reg.state)
			BUS_IDLE: begin
				if (read || write) begin
					state_next.state       = BUS_ACK;
					state_next.waitrequest = 1'b0;
				end
			end
			default: begin
				state_next.state       = BUS_IDLE;
				state_next.waitrequest = 1'b1;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= '{state: BUS_IDLE, waitrequest: 1'b1};
		end else begin
			state_reg <= state_next;
		end
	end

endmodule : avalon_wait_ctrl

//--- design/osc_override_sel.sv
// picks programmed or calibrated oscillator settings according to the force bits
module osc_override_sel
	import synth_cfg_pkg::*;
(
	// clock and reset
	input  wire logic   clk_sys,
	input  wire logic   rst_n,
	// settings in, applied settings out
	cfg_link_if.sel_mp  link
);

	osc_apply_state_t state_reg;
	osc_apply_state_t state_next;

	assign link.bias_out = state_reg.bias;
	assign link.band_out = state_reg.band;
	assign link.core_out = state_reg.core;

	// override value replaces calibration result only while its force bit is set
	always_comb begin
		state_next      = state_reg;
		state_next.bias = link.bias_force ? link.bias_val : link.cal_bias;
		state_next.band = link.band_force ? link.band_val : link.cal_band;
		state_next.core = link.core_force ? link.core_val : link.cal_core;
	end

	// state register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

endmodule : osc_override_sel

//--- dv/synth_cfg_chk.sv
// port checker for the oscillator override and pump configuration bank
module synth_cfg_chk
	import synth_cfg_pkg::*;
(
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        rst_n,
	// avalon-mm slave
	input wire logic [7:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] writedata,
	input wire logic [3:0]  byteenable,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	// calibration results
	input wire logic [8:0]  cal_bias_current,
	input wire logic [7:0]  cal_band_code,
	input wire logic [2:0]  cal_core_select,
	// applied settings and pump
	input wire logic [8:0]  osc_bias_applied,
	input wire logic [7:0]  osc_band_applied,
	input wire logic [2:0]  osc_core_applied,
	input wire logic [3:0]  charge_pump_gain,
	input wire logic        pump_tristate,
	input wire logic [12:0] pump_current_ua
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////////////
	// shadow of the force bits, captured at the edge that takes the write
	logic        take;
	logic        fb_reg;
	logic        fn_reg;
	logic        fc_reg;
	logic [12:0] pump_exp;
	assign take = write && waitrequest && byteenable[1];
	assign pump_exp = (charge_pump_gain > 4'hA) ? 13'h1ADB : 13'(charge_pump_gain) * 13'h0271;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			fb_reg <= 1'b0;
			fn_reg <= 1'b0;
			fc_reg <= 1'b0;
		end else if (take && address[7:2] == IDX_FORCE_CTRL) begin
			fb_reg <= writedata[14];
			fn_reg <= writedata[11];
		end else if (take && address[7:2] == IDX_CORE_SEL) begin
			fc_reg <= writedata[10];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// handshake, pump and override selection
	a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("no answer one cycle after a taken request");
	a_wait_one: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_read_upper: assert property (!waitrequest |-> readdata[31:16] == 16'h0000)
		else $error("read data upper half not zero");
	a_pump_off: assert property (pump_tristate == (charge_pump_gain == 4'h0))
		else $error("pump tristate does not follow gain code zero");
	a_pump_ua: assert property ($past(rst_n) |-> pump_current_ua == pump_exp)
		else $error("pump current not gain times step");
	a_bias_cal: assert property ($past(rst_n) && !$past(fb_reg) |-> osc_bias_applied == $past(cal_bias_current))
		else $error("unforced bias not taken from calibration");
	a_band_cal: assert property ($past(rst_n) && !$past(fn_reg) |-> osc_band_applied == $past(cal_band_code))
		else $error("unforced band not taken from calibration");
	a_core_cal: assert property ($past(rst_n) && !$past(fc_reg) |-> osc_core_applied == $past(cal_core_select))
		else $error("unforced core not taken from calibration");
	c_write: cover property (take);
	c_force: cover property (fb_reg && fn_reg);
	c_core: cover property (fc_reg);
	c_off: cover property (pump_tristate);
endmodule : synth_cfg_chk

bind synth_vco_cal_override_regs synth_cfg_chk chk_u (.clk_sys(clk_sys), .rst_n(rst_n), .address(address),
	.read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
	.waitrequest(waitrequest), .cal_bias_current(cal_bias_current), .cal_band_code(cal_band_code),
	.cal_core_select(cal_core_select), .osc_bias_applied(osc_bias_applied), .osc_band_applied(osc_band_applied),
	.osc_core_applied(osc_core_applied), .charge_pump_gain(charge_pump_gain), .pump_tristate(pump_tristate),
	.pump_current_ua(pump_current_ua));

//--- dv/testbench.sv
// self-checking bench for the oscillator override and pump configuration bank
module testbench
	import synth_cfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  address = 8'h00;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [31:0] writedata = 32'h00000000;
	logic [3:0]  byteenable = 4'h0;
	logic [31:0] readdata;
	logic        waitrequest;
	logic [8:0]  cal_bias_current = 9'h0AA;
	logic [7:0]  cal_band_code = 8'h11;
	logic [2:0]  cal_core_select = 3'h2;
	logic [8:0]  start_bias;
	logic [2:0]  start_core;
	logic        start_en;
	logic [8:0]  bias_app;
	logic [7:0]  band_app;
	logic [2:0]  core_app;
	logic [3:0]  gain;
	logic        tri_st;
	logic [12:0] ua;
	int          failures = 0;
	int          n_tests = 0;
	// register indices and their reset words
	logic [5:0]  ix [11] = '{6'h08, 6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16};
	logic [15:0] rv [11] = '{16'h2000, 16'h4000, 16'h1840, 16'h060E, 16'h0080, 16'h0096, 16'h0064,
		16'h27B7, 16'h3048, 16'h0409, 16'h0001};
	int          fx [5] = '{1, 3, 6, 9, 10};

	synth_vco_cal_override_regs dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .cal_bias_current(cal_bias_current), .cal_band_code(cal_band_code),
		.cal_core_select(cal_core_select), .osc_bias_cal_start_value(start_bias), .cal_start_core(start_core),
		.osc_core_start_enable(start_en), .osc_bias_applied(bias_app), .osc_band_applied(band_app),
		.osc_core_applied(core_app), .charge_pump_gain(gain), .pump_tristate(tri_st), .pump_current_ua(ua));

	// free-running system clock
	always begin
		#12.5 clk_sys = ~clk_sys;
	end

	////////////////////////////////////////////////////////////////////////////////
	// verdict, comparison and bus tasks
	task automatic tally_and_finish();
		if (failures == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : tally_and_finish

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic bus(input logic wr, input logic [5:0] i, input logic [15:0] d, input logic [3:0] be,
		output logic [31:0] rd);
		int n;
		@(posedge clk_sys);
		address <= {i, 2'b00};
		writedata <= {16'h0000, d};
		byteenable <= be;
		write <= wr;
		read <= !wr;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		rd = readdata;
		write <= 1'b0;
		read <= 1'b0;
		if (n >= 20) begin
			failures++;
			tally_and_finish();
		end
	endtask : bus

	task automatic wr(input logic [5:0] i, input logic [15:0] d);
		logic [31:0] x;
		bus(1'b1, i, d, 4'h3, x);
	endtask : wr

	task automatic rdc(input string nm, input logic [5:0] i, input logic [15:0] e);
		logic [31:0] x;
		bus(1'b0, i, 16'h0000, 4'h0, x);
		check(nm, x, {16'h0000, e});
	endtask : rdc

	// fields and applied settings both follow a write one edge after it is taken
	task automatic settle();
		repeat (2) @(posedge clk_sys);
		#1;
	endtask : settle

	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset();
		for (int i = 0; i < 11; i++) begin
			rdc("reset word", ix[i], rv[i]);
		end
		check("gain", 32'(gain), 32'h8);
		check("pump ua", 32'(ua), 32'h1388);
		check("start bias", 32'(start_bias), 32'h96);
		check("start core", 32'(start_core), 32'h6);
	endtask : t_reset

	task automatic t_readback();
		logic [15:0] p;
		logic [31:0] x;
		for (int i = 0; i < 11; i++) begin
			p = 16'h5AC3 ^ {ix[i], 10'h000};
			wr(ix[i], p);
			rdc("readback", ix[i], p);
			rdc("reread", ix[i], p);
		end
		bus(1'b1, IDX_PUMP, 16'hFFFF, 4'h1, x);
		rdc("lane0 only", IDX_PUMP, 16'h62FF);
		wr(6'h20, 16'hFFFF);
		rdc("unmapped", 6'h20, 16'h0000);
		rdc("main ctrl", IDX_MAIN_CTRL, 16'h0000);
	endtask : t_readback

	task automatic t_pump();
		int e;
		for (int c = 0; c < 16; c++) begin
			wr(IDX_PUMP, {9'h030, 4'(c), 3'h0});
			settle();
			e = (c > 10) ? 6875 : c * 625;
			check("gain", 32'(gain), 32'(c));
			check("tristate", 32'(tri_st), 32'(c == 0));
			check("pump ua", 32'(ua), 32'(e));
		end
	endtask : t_pump

	task automatic t_force();
		@(posedge clk_sys);
		cal_bias_current <= 9'h1C3;
		cal_band_code <= 8'h2A;
		cal_core_select <= 3'h3;
		wr(IDX_FORCE_CTRL, 16'h2000);
		wr(IDX_BIAS_OVR, 16'h0155);
		wr(IDX_BAND_OVR, 16'h27B7);
		wr(IDX_CORE_SEL, 16'h4C48);
		settle();
		check("bias cal", 32'(bias_app), 32'h1C3);
		check("band cal", 32'(band_app), 32'h2A);
		check("core forced", 32'(core_app), 32'h1);
		@(posedge clk_sys);
		cal_bias_current <= 9'h0E1;
		wr(IDX_FORCE_CTRL, 16'h6800);
		settle();
		check("bias forced", 32'(bias_app), 32'h155);
		check("band forced", 32'(band_app), 32'hB7);
		wr(IDX_CORE_SEL, 16'h7048);
		settle();
		check("core cal", 32'(core_app), 32'h3);
		check("start core", 32'(start_core), 32'h6);
		wr(IDX_FORCE_CTRL, 16'h2000);
		settle();
		check("bias release", 32'(bias_app), 32'h0E1);
	endtask : t_force

	task automatic t_soft();
		logic [31:0] x;
		for (int i = 0; i < 5; i++) begin
			wr(ix[fx[i]], 16'hFFFF);
		end
		wr(IDX_PUMP, 16'h1878);
		bus(1'b1, IDX_MAIN_CTRL, 16'h0002, 4'h1, x);
		settle();
		for (int i = 0; i < 5; i++) begin
			rdc("restored", ix[fx[i]], rv[fx[i]]);
		end
		rdc("pump kept", IDX_PUMP, 16'h1878);
		wr(IDX_CAL_CTRL, 16'h0001);
		settle();
		check("start enable", 32'(start_en), 32'h1);
		check("start bias", 32'(start_bias), 32'h0C3);
		rdc("cal ctrl", IDX_CAL_CTRL, 16'h0001);
		rdc("status", IDX_STATUS, 16'h000E);
	endtask : t_soft

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset();
		t_readback();
		t_pump();
		t_force();
		t_soft();
		tally_and_finish();
	end
endmodule : testbench
